// *** hw/cbt_pkg.sv ***
// constants shared by the core bus timing block
package cbt_pkg;
    localparam int CBT_ADDR_W = 24;            // external data address width
    localparam int CBT_DATA_W = 8;             // external data bus width
    localparam int CBT_IADDR_W = 8;            // internal data memory address width
    localparam int CBT_DIV_W = 3;              // core clock divider setting width
    localparam int CBT_DIVCNT_W = 7;           // divider counter, 2**7 at most
    localparam int CBT_CNT_W = 6;              // machine cycle counter width
    localparam int CBT_SYNC_STAGES = 2;        // flops on every pin input
    localparam logic [CBT_IADDR_W-1:0] CBT_SPECIAL_BASE = 8'h80; // upper 128 bytes
    localparam logic [CBT_DIV_W-1:0] CBT_DIV_UNDIVIDED = 3'h0;
    localparam logic [CBT_CNT_W-1:0] CBT_XMOVE_BASE_CYC = 6'h02; // address cycle plus access
    localparam logic [CBT_CNT_W-1:0] CBT_CNT_ONE = 6'h01;
    localparam logic [CBT_DIVCNT_W-1:0] CBT_DIVCNT_RST = 7'h00;
    localparam logic [CBT_ADDR_W-1:0] CBT_ADDR_RST = 24'h000000;
    localparam logic [CBT_DATA_W-1:0] CBT_DATA_RST = 8'h00;
    localparam real CBT_MCLK_PERIOD_NS = 8.0;  // 125 MHz
    // machine sequencer states, gray along idle -> first -> rest
    typedef enum logic [1:0] {
        CBT_ST_IDLE = 2'h0,
        CBT_ST_FIRST = 2'h1,
        CBT_ST_REST = 2'h3
    } cbt_state_t;
endpackage

// *** hw/cbt_sync.sv ***
// two flop synchroniser for pin inputs
`timescale 1ns/1ps
module cbt_sync #(
    parameter int WIDTH = 8
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_reg;

    // first stage feeds only the second
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            meta_reg <= '0;
            dout <= '0;
        end else begin
            meta_reg <= din;
            dout <= meta_reg;
        end
    end
endmodule

// *** hw/cbt_core.sv ***
// machine cycle sequencer, address latch strobe, external data port, special space decode
`timescale 1ns/1ps
module cbt_core
    import cbt_pkg::*;
#(
    parameter int WAIT_W = 3,
    parameter int ICYC_W = 3
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [CBT_DIV_W-1:0] core_clock_divider_setting,
    input wire logic [WAIT_W-1:0] ext_wait_state_count,
    input wire logic instr_start,
    input wire logic [ICYC_W-1:0] instr_cycles,
    input wire logic external_data_move,
    input wire logic xmove_write,
    input wire logic [CBT_ADDR_W-1:0] xmove_addr,
    input wire logic [CBT_DATA_W-1:0] xmove_wdata,
    input wire logic iaddr_valid,
    input wire logic [CBT_IADDR_W-1:0] iaddr,
    input wire logic iaddr_direct,
    input wire logic iaddr_bank,
    input wire logic [CBT_DATA_W-1:0] xdata_i,
    output logic core_step_reg,
    output logic tmr_tick_reg,
    output logic busy_reg,
    output logic ale_reg,
    output logic prog_fetch_ext_b_reg,
    output logic [CBT_ADDR_W-1:0] xaddr_reg,
    output logic xrd_b_reg,
    output logic xwr_b_reg,
    output logic [CBT_DATA_W-1:0] xdata_o_reg,
    output logic xdata_oe_reg,
    output logic [CBT_DATA_W-1:0] rdata_reg,
    output logic rdata_valid_reg,
    output logic special_sel_reg,
    output logic iram_sel_reg,
    output logic [CBT_IADDR_W-2:0] special_index_reg
);
    // refuse widths whose longest instruction overflows the cycle counter
    if (WAIT_W < 1 || ICYC_W < 1 || (1 << WAIT_W) + (1 << ICYC_W) >= (1 << CBT_CNT_W)) begin : g_width_check
        $error("cbt_core: wait or instruction width too large for cycle counter");
    end

    cbt_state_t state_reg;
    logic [CBT_DIVCNT_W-1:0] div_cnt_reg;
    logic [CBT_DIVCNT_W-1:0] div_mask;
    logic step_now;
    logic [CBT_CNT_W-1:0] cyc_left_reg;
    logic [CBT_CNT_W-1:0] total_next;
    logic [CBT_CNT_W-1:0] base_cyc;
    logic xmove_reg;
    logic write_reg;
    logic accept;
    logic last_cyc;
    logic [CBT_DATA_W-1:0] xdata_sync;

    ////////////////////////////////////////////////////////////////////////
    // pin data through two flops
    cbt_sync #(.WIDTH(CBT_DATA_W)) u_sync (
        .mclk(mclk),
        .rst_b(rst_b),
        .din(xdata_i),
        .dout(xdata_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // core clock divider: step every mclk when undivided
    assign div_mask = CBT_DIVCNT_W'((1 << core_clock_divider_setting) - 1);
    assign step_now = (div_cnt_reg & div_mask) == div_mask;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            div_cnt_reg <= CBT_DIVCNT_RST;
        end else begin
            div_cnt_reg <= div_cnt_reg + 1'b1;
        end
    end

    // one machine cycle per core step, timers tick on it
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            core_step_reg <= 1'b0;
            tmr_tick_reg <= 1'b0;
        end else begin
            core_step_reg <= step_now;
            tmr_tick_reg <= step_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // instruction length, data moves stretched by wait count
    always_comb begin
        base_cyc = CBT_CNT_W'(instr_cycles);
        if (base_cyc == '0)
            base_cyc = CBT_CNT_ONE;
        if (external_data_move && base_cyc < CBT_XMOVE_BASE_CYC)
            base_cyc = CBT_XMOVE_BASE_CYC;
        total_next = base_cyc;
        if (external_data_move)
            total_next = base_cyc + CBT_CNT_W'(ext_wait_state_count);
    end

    assign last_cyc = (state_reg != CBT_ST_IDLE) && (cyc_left_reg == CBT_CNT_ONE);
    assign accept = step_now && instr_start && ((state_reg == CBT_ST_IDLE) || last_cyc);

    ////////////////////////////////////////////////////////////////////////
    // machine cycle sequencer and latch enable
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            state_reg <= CBT_ST_IDLE;
            cyc_left_reg <= '0;
            ale_reg <= 1'b0;
        end else if (step_now) begin
            if (accept) begin
                state_reg <= CBT_ST_FIRST;
                cyc_left_reg <= total_next;
                ale_reg <= 1'b1;
            end else begin
                unique case (state_reg)
                    CBT_ST_IDLE: begin
                        ale_reg <= 1'b0;
                    end
                    CBT_ST_FIRST, CBT_ST_REST: begin
                        ale_reg <= 1'b0;
                        cyc_left_reg <= cyc_left_reg - 1'b1;
                        state_reg <= last_cyc ? CBT_ST_IDLE : CBT_ST_REST;
                    end
                    default: begin
                        state_reg <= CBT_ST_IDLE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            busy_reg <= 1'b0;
        end else if (step_now) begin
            // set while another machine cycle follows the one starting now
            busy_reg <= accept ? (total_next != CBT_CNT_ONE)
                : (state_reg != CBT_ST_IDLE && cyc_left_reg > CBT_CNT_ONE + CBT_CNT_ONE);
        end
    end

    // program always from on-chip storage
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            prog_fetch_ext_b_reg <= 1'b1;
        end else begin
            prog_fetch_ext_b_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // external data port: address in first cycle, strobes until the end
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            xmove_reg <= 1'b0;
            write_reg <= 1'b0;
            xaddr_reg <= CBT_ADDR_RST;
            xdata_o_reg <= CBT_DATA_RST;
            xrd_b_reg <= 1'b1;
            xwr_b_reg <= 1'b1;
            xdata_oe_reg <= 1'b0;
        end else if (step_now) begin
            if (accept) begin
                xmove_reg <= external_data_move;
                write_reg <= xmove_write;
                xrd_b_reg <= 1'b1;
                xwr_b_reg <= 1'b1;
                xdata_oe_reg <= 1'b0;
                if (external_data_move) begin
                    xaddr_reg <= xmove_addr;
                    xdata_o_reg <= xmove_wdata;
                end
            end else if (state_reg == CBT_ST_IDLE || last_cyc) begin
                xrd_b_reg <= 1'b1;
                xwr_b_reg <= 1'b1;
                xdata_oe_reg <= 1'b0;
                xmove_reg <= 1'b0;
            end else if (xmove_reg) begin
                xrd_b_reg <= write_reg;
                xwr_b_reg <= !write_reg;
                xdata_oe_reg <= write_reg;
            end
        end
    end

    // read data taken at end of the stretched access
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            rdata_reg <= CBT_DATA_RST;
            rdata_valid_reg <= 1'b0;
        end else begin
            rdata_valid_reg <= 1'b0;
            if (step_now && last_cyc && xmove_reg && !write_reg) begin
                rdata_reg <= xdata_sync;
                rdata_valid_reg <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // internal data decode: special space only on direct upper addresses
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            special_sel_reg <= 1'b0;
            iram_sel_reg <= 1'b0;
            special_index_reg <= '0;
        end else begin
            special_sel_reg <= iaddr_valid && iaddr_direct && !iaddr_bank
                && (iaddr >= CBT_SPECIAL_BASE);
            iram_sel_reg <= iaddr_valid && (iaddr_bank || !iaddr_direct
                || (iaddr < CBT_SPECIAL_BASE));
            special_index_reg <= iaddr[CBT_IADDR_W-2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    logic [CBT_CNT_W-1:0] strb_steps_reg;
    logic [CBT_CNT_W-1:0] strb_expect_reg;
    logic [CBT_CNT_W-1:0] strb_pend_reg;
    // strobe length model; expectation moves over only while strobes are idle
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            strb_steps_reg <= '0;
            strb_expect_reg <= '0;
            strb_pend_reg <= '0;
        end else begin
            if (accept && external_data_move)
                strb_pend_reg <= total_next - CBT_CNT_ONE;
            if (xrd_b_reg && xwr_b_reg)
                strb_expect_reg <= strb_pend_reg;
            if (xrd_b_reg && xwr_b_reg)
                strb_steps_reg <= '0;
            else if (step_now)
                strb_steps_reg <= strb_steps_reg + 1'b1;
        end
    end

    a_tick_full_rate: assert property (
        (core_clock_divider_setting == CBT_DIV_UNDIVIDED && rst_b)[*2] |-> tmr_tick_reg && core_step_reg)
        else $error("timer tick missing at full rate");
    a_ale_first_high: assert property (accept |=> ale_reg)
        else $error("latch enable not high in first cycle");
    a_ale_single_whole: assert property (
        accept && total_next == CBT_CNT_ONE ##1 !step_now |-> ale_reg)
        else $error("latch enable dropped early");
    a_ale_later_low: assert property (state_reg == CBT_ST_REST |-> !ale_reg)
        else $error("latch enable high after first cycle");
    a_strobe_length: assert property (
        $rose(xrd_b_reg && xwr_b_reg) |-> strb_steps_reg == strb_expect_reg)
        else $error("strobe length differs from base plus wait");
    a_addr_held: assert property (
        !xrd_b_reg || !xwr_b_reg |=> $stable(xaddr_reg) || xrd_b_reg && xwr_b_reg)
        else $error("address moved during strobe");
    a_no_ext_fetch: assert property (prog_fetch_ext_b_reg)
        else $error("external program fetch attempted");
    a_special_direct: assert property (
        special_sel_reg |-> $past(iaddr_direct) && $past(iaddr) >= CBT_SPECIAL_BASE)
        else $error("special space selected without direct upper address");
    a_bank_outside: assert property (
        $past(iaddr_bank) && $past(iaddr_valid) |-> iram_sel_reg && !special_sel_reg)
        else $error("register bank reached special space");
    a_read_capture: assert property (
        !xrd_b_reg && step_now && last_cyc |=> rdata_valid_reg ##1 !rdata_valid_reg)
        else $error("read data not captured at access end");

    c_single_cycle: cover property (accept && total_next == CBT_CNT_ONE);
    c_xmove_read_wait: cover property (accept && external_data_move && !xmove_write && ext_wait_state_count != '0);
    c_xmove_write: cover property (!xwr_b_reg ##[1:40] xwr_b_reg);
    c_special_hit: cover property (special_sel_reg);
endmodule

// *** verif/cbt_xram.sv ***
// behavioural external parallel ram on the far side of the data port
`timescale 1ns/1ps
module cbt_xram
    import cbt_pkg::*;
(
    input wire logic mclk,
    input wire logic slow,
    input wire logic [CBT_ADDR_W-1:0] xaddr,
    input wire logic xrd_b,
    input wire logic xwr_b,
    input wire logic [CBT_DATA_W-1:0] xdata_o,
    input wire logic xdata_oe,
    output logic [CBT_DATA_W-1:0] xdata_i
);
    logic [CBT_DATA_W-1:0] mem [0:255];
    logic [CBT_DATA_W-1:0] last_reg = 8'h00;
    int lat_reg = 0;
    logic drive;
    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
    end
    // write capture and read latency count; a slow part needs more wait cycles
    always @(posedge mclk) begin
        if (!xwr_b && xdata_oe) mem[xaddr[7:0]] <= xdata_o;
        lat_reg <= xrd_b ? 0 : lat_reg + 1;
        if (drive) last_reg <= mem[xaddr[7:0]];
    end
    // released bus shows the inverse of the last value, not a stale copy
    assign drive = !xrd_b && (!slow || lat_reg >= 2);
    assign xdata_i = drive ? mem[xaddr[7:0]] : ~last_reg;
endmodule

// *** verif/tb.sv ***
// self-checking bench for the core bus timing block
`timescale 1ns/1ps
module tb;
    import cbt_pkg::*;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [CBT_DIV_W-1:0] div_set = 3'h0;
    logic [2:0] wait_cnt = 3'h0;
    logic [2:0] cyc = 3'h1;
    logic start = 1'b0, xmove = 1'b0, wr = 1'b0, slow = 1'b0;
    logic [CBT_ADDR_W-1:0] addr = 24'h000000;
    logic [CBT_DATA_W-1:0] wdata = 8'h00;
    logic ivalid = 1'b0, idirect = 1'b0, ibank = 1'b0;
    logic [CBT_IADDR_W-1:0] iaddr = 8'h00;
    logic step, tick, busy, ale, pfe_b, xrd_b, xwr_b, xoe, rvalid, ssel, isel;
    logic [CBT_ADDR_W-1:0] xaddr;
    logic [CBT_DATA_W-1:0] xdo, xdi, rdata;
    logic [CBT_IADDR_W-2:0] sidx;
    int mismatches = 0;
    int n_checks = 0;
    cbt_core u_cbt_core (.mclk(mclk), .rst_b(rst_b), .core_clock_divider_setting(div_set),
        .ext_wait_state_count(wait_cnt), .instr_start(start), .instr_cycles(cyc), .external_data_move(xmove),
        .xmove_write(wr), .xmove_addr(addr), .xmove_wdata(wdata), .iaddr_valid(ivalid), .iaddr(iaddr),
        .iaddr_direct(idirect), .iaddr_bank(ibank), .xdata_i(xdi), .core_step_reg(step), .tmr_tick_reg(tick),
        .busy_reg(busy), .ale_reg(ale), .prog_fetch_ext_b_reg(pfe_b), .xaddr_reg(xaddr), .xrd_b_reg(xrd_b),
        .xwr_b_reg(xwr_b), .xdata_o_reg(xdo), .xdata_oe_reg(xoe), .rdata_reg(rdata), .rdata_valid_reg(rvalid),
        .special_sel_reg(ssel), .iram_sel_reg(isel), .special_index_reg(sidx));
    cbt_xram u_cbt_xram (.mclk(mclk), .slow(slow), .xaddr(xaddr), .xrd_b(xrd_b), .xwr_b(xwr_b),
        .xdata_o(xdo), .xdata_oe(xoe), .xdata_i(xdi));
    ////////////////////////////////////////////////////////////////////////////////
    // clock, reset and watchdog
    initial begin
        forever #4 mclk = ~mclk;
    end
    initial begin
        #(5000 * 8);
        mismatches++;
        summarize();
    end
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // one instruction; for a read, d carries the expected data
    task automatic run(input logic [2:0] c, input logic m, input logic w, input logic [23:0] a, input logic [7:0] d);
        int k;
        int lo;
        @(posedge mclk);
        cyc <= c;
        xmove <= m;
        wr <= w;
        addr <= a;
        wdata <= d;
        start <= 1'b1;
        @(posedge mclk);
        start <= 1'b0;
        k = 0;
        while (ale !== 1'b1 && k < 8) begin
            @(negedge mclk);
            k++;
        end
        chk("ale_first", ale, 1'b1);
        chk("busy_first", busy, m || c > 1);
        chk("prog_fetch_ext_b", pfe_b, 1'b1);
        if (!m) begin
            for (k = 0; k < ((c > 1) ? c - 1 : 1); k++) begin
                @(negedge mclk);
                chk("ale_later", ale, 1'b0);
                chk("busy", busy, k + 2 < c);
                chk("strobes_idle", {xrd_b, xwr_b}, 2'b11);
            end
        end else begin
            @(negedge mclk);
            chk("xaddr", xaddr, a);
            chk("xoe", xoe, w);
            if (w) chk("xdata_o", xdo, d);
            lo = 0;
            while ((xrd_b === 1'b0 || xwr_b === 1'b0) && lo < 20) begin
                chk("xaddr_held", xaddr, a);
                chk("strobe_sel", {xrd_b, xwr_b}, w ? 2'b10 : 2'b01);
                lo++;
                @(negedge mclk);
            end
            chk("strobe_len", lo, ((c < 2) ? 2 : c) + wait_cnt - 1);
            chk("rvalid", rvalid, !w);
            if (!w) chk("rdata", rdata, d);
        end
    endtask
    task automatic t_instr();
        run(3'h1, 1'b0, 1'b0, 24'h0, 8'h0);
        run(3'h3, 1'b0, 1'b0, 24'h0, 8'h0);
        run(3'h2, 1'b0, 1'b0, 24'h0, 8'h0);
        $display("test instr done");
    endtask
    // writes over a table of base cycles and wait counts, then read back fast and slow
    task automatic t_move();
        logic [2:0] ctab [4] = '{3'h1, 3'h2, 3'h3, 3'h2};
        logic [2:0] wtab [4] = '{3'h0, 3'h1, 3'h2, 3'h7};
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk) wait_cnt <= wtab[i];
            run(ctab[i], 1'b1, 1'b1, {8'ha5, 8'h3c, 8'(i + 8'h10)}, 8'(8'hc1 + i));
        end
        @(posedge mclk) wait_cnt <= 3'h3;
        run(3'h2, 1'b1, 1'b0, 24'ha53c10, 8'hc1);
        @(posedge mclk) slow <= 1'b1;
        wait_cnt <= 3'h7;
        run(3'h3, 1'b1, 1'b0, 24'hff0013, 8'hc4);
        @(posedge mclk) slow <= 1'b0;
        $display("test move done");
    endtask
    // special space decode: {address, direct, bank, expected special}
    task automatic t_decode();
        logic [10:0] dtab [4] = '{{8'h80, 3'b101}, {8'h7f, 3'b100}, {8'hff, 3'b000}, {8'h85, 3'b110}};
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk);
            ivalid <= 1'b1;
            {iaddr, idirect, ibank} <= dtab[i][10:1];
            @(posedge mclk);
            @(negedge mclk);
            chk("special_sel", ssel, dtab[i][0]);
            chk("iram_sel", isel, !dtab[i][0]);
            if (dtab[i][0]) chk("special_index", sidx, dtab[i][9:3]);
        end
        @(posedge mclk) ivalid <= 1'b0;
        $display("test decode done");
    endtask
    // timer ticks: every clock undivided, every second clock at setting 1
    task automatic t_div(input logic [2:0] s, input int exp);
        int n;
        @(posedge mclk) div_set <= s;
        repeat (8) @(posedge mclk);
        n = 0;
        repeat (32) begin
            @(negedge mclk);
            n += (tick === 1'b1);
            chk("step_vs_tick", step, tick);
        end
        chk("tick_count", n, exp);
        // at half rate a single cycle instruction keeps latch enable up for both clocks
        if (s == 3'h1) begin
            while (step !== 1'b1) @(negedge mclk);
            @(posedge mclk);
            cyc <= 3'h1;
            xmove <= 1'b0;
            start <= 1'b1;
            @(posedge mclk);
            start <= 1'b0;
            @(negedge mclk);
            chk("ale_half_first", ale, 1'b1);
            @(negedge mclk);
            chk("ale_half_whole", ale, 1'b1);
            @(negedge mclk);
            chk("ale_half_after", ale, 1'b0);
        end
        $display("test divider done");
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        rst_b <= 1'b1;
        t_div(3'h0, 32);
        t_instr();
        t_move();
        t_decode();
        t_div(3'h1, 16);
        summarize();
    end
endmodule
